// ### tlce_defs.vh
// Register map, field positions, reset values and codes of the transmit line code encoder
`ifndef TLCE_DEFS_VH
`define TLCE_DEFS_VH

`define TLCE_CTRL0_OFF   8'h00
`define TLCE_CTRL1_OFF   8'h04
`define TLCE_STATUS_OFF  8'h08
`define TLCE_BITCNT0_OFF 8'h0C
`define TLCE_BITCNT1_OFF 8'h10
`define TLCE_SUBCNT0_OFF 8'h14
`define TLCE_SUBCNT1_OFF 8'h18

`define TLCE_CTRL_W      4
`define TLCE_CTRL_SR     0
`define TLCE_CTRL_RATE   1
`define TLCE_CTRL_BO     3
`define TLCE_CTRL_RST    4'h0

`define TLCE_RATE_E3     2'h0
`define TLCE_RATE_DS3    2'h1
`define TLCE_RATE_STS1   2'h2

`define TLCE_ST_STRIDE   8
`define TLCE_ST_SR       0
`define TLCE_ST_E3       1
`define TLCE_ST_STS1     2
`define TLCE_ST_BO       3
`define TLCE_ST_HOST     4
`define TLCE_ST_NEGERR   5

`define TLCE_SYM_ZERO    2'h0
`define TLCE_SYM_ONE     2'h1
`define TLCE_SYM_B       2'h2
`define TLCE_SYM_V       2'h3

`endif

// ### tlce_sync.v
// Two-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/1ps
module tlce_sync #(
   parameter WIDTH = 1
) (
   input  wire             mclk,
   input  wire             srst,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta;

   always @(posedge mclk) begin
      if (srst) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// ### tlce_zsub.v
// One channel of B3ZS / HDB3 zero substitution with alternate mark inversion
`timescale 1ns/1ps
`include "tlce_defs.vh"
module tlce_zsub (
   input  wire mclk,
   input  wire srst,
   input  wire enable,
   input  wire hdb3,
   input  wire bit_strobe,
   input  wire nrz_bit,
   output reg  pulse_pos,
   output reg  pulse_neg,
   output reg  subst_pulse
);

   // Four symbols, newest in [1:0]; B3ZS only uses the newest three
   reg  [7:0] pipe;
   reg  [7:0] next_pipe;
   reg        last_pos;
   reg        odd_marks;
   reg        next_odd;
   reg        pol;
   wire [1:0] out_sym;
   wire [7:0] shifted;
   wire       grp_zero;

   function is_bmark;
      input [1:0] s;
      begin
         is_bmark = (s == `TLCE_SYM_ONE) || (s == `TLCE_SYM_B);
      end
   endfunction

   assign out_sym  = hdb3 ? pipe[7:6] : pipe[5:4];
   assign shifted  = {pipe[5:0], 1'b0, nrz_bit};
   assign grp_zero = hdb3 ? (shifted == 8'h00) : (shifted[5:0] == 6'h00);

   always @* begin
      next_pipe = shifted;
      // Parity of ordinary pulses since the last violation, counting the bit leaving now
      if (out_sym == `TLCE_SYM_V)
         next_odd = 1'b0;
      else
         next_odd = odd_marks ^ is_bmark(out_sym);
      if (grp_zero) begin
         next_pipe[1:0] = `TLCE_SYM_V;
         if (!next_odd) begin
            // Even count: lead the run with a B so the count turns odd
            if (hdb3)
               next_pipe[7:6] = `TLCE_SYM_B;
            else
               next_pipe[5:4] = `TLCE_SYM_B;
         end
      end
      if (out_sym == `TLCE_SYM_V)
         pol = last_pos;
      else
         pol = ~last_pos;
   end

   always @(posedge mclk) begin
      if (srst || !enable) begin
         pipe        <= 8'h00;
         last_pos    <= 1'b0;
         odd_marks   <= 1'b0;
         pulse_pos   <= 1'b0;
         pulse_neg   <= 1'b0;
         subst_pulse <= 1'b0;
      end else begin
         subst_pulse <= bit_strobe & grp_zero;
         if (bit_strobe) begin
            pipe      <= next_pipe;
            odd_marks <= next_odd;
            if (out_sym == `TLCE_SYM_ZERO) begin
               pulse_pos <= 1'b0;
               pulse_neg <= 1'b0;
            end else begin
               pulse_pos <= pol;
               pulse_neg <= ~pol;
            end
            if (is_bmark(out_sym))
               last_pos <= pol;
         end
      end
   end

endmodule

// ### tlce_top.v
// Two-channel transmit line code encoder with APB configuration
// Contract
// - Each channel configured alone, pins or bits
// - Single rail uses positive rail only
// - Pin high or bit 0 one: single rail
// - Pin low or bit 0 zero: dual rail
// - Single rail: B3ZS for DS3/STS-1, HDB3 E3
// - B3ZS replaces three zeros by B0V/00V
// - B3ZS keeps odd pulses between violations
// - HDB3 replaces four zeros by 000V/B00V
// - HDB3 keeps odd pulses between violations
// - Dual rail bypasses the encoder automatically
// - Dual rail passes violations as data
// - Encoder and decoder active only single rail
// - Select high or bit one disables build-out
// - E3 rate forces build-out disabled
// - Rails captured on transmit clock falling edge
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tlce_defs.vh"
module tlce_top #(
   parameter CNT_W = 16
) (
   input  wire        mclk,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        host_mode,
   input  wire [1:0]  rail_format_select,
   input  wire [1:0]  build_out_select,
   input  wire [1:0]  rate_select_e3,
   input  wire [1:0]  rate_select_sts1,
   input  wire [1:0]  tx_line_clock,
   input  wire [1:0]  tx_positive_rail,
   input  wire [1:0]  tx_negative_rail,
   output reg  [1:0]  line_pos,
   output reg  [1:0]  line_neg,
   output reg  [1:0]  line_bit_strobe,
   output reg  [1:0]  build_out_enable,
   output reg  [1:0]  rate_is_e3,
   output reg  [1:0]  rate_is_sts1,
   output reg  [1:0]  rx_decoder_enable
);

   localparam NPIN = 15;

   wire [NPIN-1:0]    pin_s;
   wire               host_s;
   wire [1:0]         rail_s;
   wire [1:0]         bo_s;
   wire [1:0]         e3_s;
   wire [1:0]         sts1_s;
   wire [1:0]         clk_s;
   wire [1:0]         pos_s;
   wire [1:0]         neg_s;

   reg  [7:0]         ctrl;
   reg  [1:0]         clk_prev;
   wire [1:0]         fall;
   reg  [1:0]         single;
   reg  [1:0]         is_e3;
   reg  [1:0]         is_sts1;
   reg  [1:0]         bo_en;
   reg  [1:0]         dr_pos;
   reg  [1:0]         dr_neg;
   reg  [1:0]         strobe_q;
   reg  [1:0]         neg_err;
   reg  [2*CNT_W-1:0] bit_cnt;
   reg  [2*CNT_W-1:0] sub_cnt;
   reg  [31:0]        status;
   reg  [31:0]        next_prdata;
   reg  [1:0]         rate_code;
   wire [1:0]         enc_pos;
   wire [1:0]         enc_neg;
   wire [1:0]         enc_sub;
   wire               apb_wr;
   wire               apb_rd_setup;
   integer            ci;
   integer            cj;
   integer            ck;

   function addr_ok;
      input [7:0] a;
      begin
         case (a)
            `TLCE_CTRL0_OFF:   addr_ok = 1'b1;
            `TLCE_CTRL1_OFF:   addr_ok = 1'b1;
            `TLCE_STATUS_OFF:  addr_ok = 1'b1;
            `TLCE_BITCNT0_OFF: addr_ok = 1'b1;
            `TLCE_BITCNT1_OFF: addr_ok = 1'b1;
            `TLCE_SUBCNT0_OFF: addr_ok = 1'b1;
            `TLCE_SUBCNT1_OFF: addr_ok = 1'b1;
            default:           addr_ok = 1'b0;
         endcase
      end
   endfunction

   function [31:0] widen;
      input [CNT_W-1:0] v;
      begin
         widen = 32'h0;
         widen[CNT_W-1:0] = v;
      end
   endfunction

   // Every pin is foreign to mclk, the line clocks included
   tlce_sync #(
      .WIDTH    (NPIN)
   ) u_sync (
      .mclk     (mclk),
      .srst     (srst),
      .async_in ({host_mode, rail_format_select, build_out_select, rate_select_e3,
                  rate_select_sts1, tx_line_clock, tx_positive_rail, tx_negative_rail}),
      .sync_out (pin_s)
   );

   assign host_s = pin_s[14];
   assign rail_s = pin_s[13:12];
   assign bo_s   = pin_s[11:10];
   assign e3_s   = pin_s[9:8];
   assign sts1_s = pin_s[7:6];
   assign clk_s  = pin_s[5:4];
   assign pos_s  = pin_s[3:2];
   assign neg_s  = pin_s[1:0];

   // Rails travel through the same two flops as the clock, so they line up with its edge
   assign fall = clk_prev & ~clk_s;

   // Per-channel configuration source: host bits or hardware pins
   always @* begin
      rate_code = `TLCE_RATE_DS3;
      for (ci = 0; ci < 2; ci = ci + 1) begin
         if (host_s) begin
            single[ci] = ctrl[ci*`TLCE_CTRL_W+`TLCE_CTRL_SR];
            rate_code  = ctrl[ci*`TLCE_CTRL_W+`TLCE_CTRL_RATE +: 2];
            is_e3[ci]  = (rate_code == `TLCE_RATE_E3);
            // Reserved rate code falls back to DS3
            is_sts1[ci] = (rate_code == `TLCE_RATE_STS1);
            bo_en[ci]  = ~ctrl[ci*`TLCE_CTRL_W+`TLCE_CTRL_BO] & ~is_e3[ci];
         end else begin
            single[ci]  = rail_s[ci];
            is_e3[ci]   = e3_s[ci];
            is_sts1[ci] = sts1_s[ci] & ~e3_s[ci];
            bo_en[ci]   = ~bo_s[ci] & ~is_e3[ci];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_enc
         tlce_zsub u_zsub (
            .mclk        (mclk),
            .srst        (srst),
            .enable      (single[g]),
            .hdb3        (is_e3[g]),
            .bit_strobe  (fall[g]),
            .nrz_bit     (pos_s[g]),
            .pulse_pos   (enc_pos[g]),
            .pulse_neg   (enc_neg[g]),
            .subst_pulse (enc_sub[g])
         );
      end
   endgenerate

   // Line side registers: encoder output or dual-rail pass-through
   always @(posedge mclk) begin
      if (srst) begin
         clk_prev          <= 2'h0;
         dr_pos            <= 2'h0;
         dr_neg            <= 2'h0;
         strobe_q          <= 2'h0;
         line_pos          <= 2'h0;
         line_neg          <= 2'h0;
         line_bit_strobe   <= 2'h0;
         build_out_enable  <= 2'h0;
         rate_is_e3        <= 2'h0;
         rate_is_sts1      <= 2'h0;
         rx_decoder_enable <= 2'h0;
      end else begin
         clk_prev          <= clk_s;
         strobe_q          <= fall;
         line_bit_strobe   <= strobe_q;
         build_out_enable  <= bo_en;
         rate_is_e3        <= is_e3;
         rate_is_sts1      <= is_sts1;
         rx_decoder_enable <= single;
         for (cj = 0; cj < 2; cj = cj + 1) begin
            if (fall[cj]) begin
               // Both rails high is a violation and still goes out as data
               dr_pos[cj] <= pos_s[cj];
               dr_neg[cj] <= neg_s[cj];
            end
            if (single[cj]) begin
               line_pos[cj] <= enc_pos[cj];
               line_neg[cj] <= enc_neg[cj];
            end else begin
               line_pos[cj] <= dr_pos[cj];
               line_neg[cj] <= dr_neg[cj];
            end
         end
      end
   end

   // APB slave: zero wait states, error on unmapped or unaligned address
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~addr_ok(paddr);
   assign apb_wr       = psel & penable & pwrite & addr_ok(paddr);
   assign apb_rd_setup = psel & ~penable & ~pwrite;

   always @* begin
      status = 32'h0;
      for (ck = 0; ck < 2; ck = ck + 1) begin
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_SR]     = single[ck];
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_E3]     = is_e3[ck];
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_STS1]   = is_sts1[ck];
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_BO]     = bo_en[ck];
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_HOST]   = host_s;
         status[ck*`TLCE_ST_STRIDE+`TLCE_ST_NEGERR] = neg_err[ck];
      end
   end

   always @* begin
      case (paddr)
         `TLCE_CTRL0_OFF:   next_prdata = {28'h0, ctrl[3:0]};
         `TLCE_CTRL1_OFF:   next_prdata = {28'h0, ctrl[7:4]};
         `TLCE_STATUS_OFF:  next_prdata = status;
         `TLCE_BITCNT0_OFF: next_prdata = widen(bit_cnt[CNT_W-1:0]);
         `TLCE_BITCNT1_OFF: next_prdata = widen(bit_cnt[2*CNT_W-1:CNT_W]);
         `TLCE_SUBCNT0_OFF: next_prdata = widen(sub_cnt[CNT_W-1:0]);
         `TLCE_SUBCNT1_OFF: next_prdata = widen(sub_cnt[2*CNT_W-1:CNT_W]);
         default:           next_prdata = 32'h0;
      endcase
   end

   // Read data is loaded in the setup cycle so it is ready at the access edge
   always @(posedge mclk) begin
      if (srst)
         prdata <= 32'h0;
      else if (apb_rd_setup)
         prdata <= next_prdata;
   end

   always @(posedge mclk) begin
      if (srst) begin
         ctrl <= {`TLCE_CTRL_RST, `TLCE_CTRL_RST};
      end else if (apb_wr) begin
         if (paddr == `TLCE_CTRL0_OFF)
            ctrl[3:0] <= pwdata[3:0];
         if (paddr == `TLCE_CTRL1_OFF)
            ctrl[7:4] <= pwdata[3:0];
      end
   end

   // Sticky flag: far end drove the negative rail while single rail was selected
   always @(posedge mclk) begin
      if (srst) begin
         neg_err <= 2'h0;
      end else begin
         if (apb_wr && paddr == `TLCE_STATUS_OFF) begin
            neg_err[0] <= (neg_err[0] & ~pwdata[`TLCE_ST_NEGERR]) | (single[0] & fall[0] & neg_s[0]);
            neg_err[1] <= (neg_err[1] & ~pwdata[`TLCE_ST_STRIDE+`TLCE_ST_NEGERR])
                          | (single[1] & fall[1] & neg_s[1]);
         end else begin
            neg_err <= neg_err | (single & fall & neg_s);
         end
      end
   end

   // Counters wrap; a write clears one, and an event in the same cycle still counts
   always @(posedge mclk) begin
      if (srst) begin
         bit_cnt <= {2*CNT_W{1'b0}};
         sub_cnt <= {2*CNT_W{1'b0}};
      end else begin
         if (apb_wr && paddr == `TLCE_BITCNT0_OFF)
            bit_cnt[CNT_W-1:0] <= {{CNT_W-1{1'b0}}, fall[0]};
         else if (fall[0])
            bit_cnt[CNT_W-1:0] <= bit_cnt[CNT_W-1:0] + 1'b1;
         if (apb_wr && paddr == `TLCE_BITCNT1_OFF)
            bit_cnt[2*CNT_W-1:CNT_W] <= {{CNT_W-1{1'b0}}, fall[1]};
         else if (fall[1])
            bit_cnt[2*CNT_W-1:CNT_W] <= bit_cnt[2*CNT_W-1:CNT_W] + 1'b1;
         if (apb_wr && paddr == `TLCE_SUBCNT0_OFF)
            sub_cnt[CNT_W-1:0] <= {{CNT_W-1{1'b0}}, enc_sub[0]};
         else if (enc_sub[0])
            sub_cnt[CNT_W-1:0] <= sub_cnt[CNT_W-1:0] + 1'b1;
         if (apb_wr && paddr == `TLCE_SUBCNT1_OFF)
            sub_cnt[2*CNT_W-1:CNT_W] <= {{CNT_W-1{1'b0}}, enc_sub[1]};
         else if (enc_sub[1])
            sub_cnt[2*CNT_W-1:CNT_W] <= sub_cnt[2*CNT_W-1:CNT_W] + 1'b1;
      end
   end

endmodule

// ### tlce_assertions.sv
// Checker on the transmit encoder top ports
`timescale 1ns/1ps
module tlce_chk #(
   parameter CNT_W = 16
) (
   input wire       mclk,
   input wire       srst,
   input wire       psel,
   input wire       penable,
   input wire       pready,
   input wire       pslverr,
   input wire       host_mode,
   input wire [1:0] rail_format_select,
   input wire [1:0] build_out_select,
   input wire [1:0] rate_select_e3,
   input wire [1:0] line_pos,
   input wire [1:0] line_neg,
   input wire [1:0] line_bit_strobe,
   input wire [1:0] build_out_enable,
   input wire [1:0] rate_is_e3,
   input wire [1:0] rate_is_sts1,
   input wire [1:0] rx_decoder_enable
);
   reg [2:0] age;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // Pin checks wait until the synchronisers hold post-reset values
   always @(posedge mclk) begin
      if (srst)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end
   a_bo_not_e3: assert property ((build_out_enable & rate_is_e3) == 2'h0)
      else $error("build-out enabled at E3 rate");
   a_one_rate: assert property ((rate_is_e3 & rate_is_sts1) == 2'h0)
      else $error("two rates at once");
   a_no_double: assert property (line_bit_strobe[0] && rx_decoder_enable[0] |-> !(line_pos[0] && line_neg[0]))
      else $error("both rails marked while encoding");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   a_ready_high: assert property (pready)
      else $error("ready dropped");
   a_bit_hold: assert property (line_bit_strobe[0] |=>
      (!line_bit_strobe[0] && $stable({line_pos[0], line_neg[0]})) [*5])
      else $error("line bit not held");
   a_hw_format: assert property (!host_mode [*6] ##0 age == 3'h7
      |-> rx_decoder_enable[0] == $past(rail_format_select[0], 3))
      else $error("encoder enable does not follow format pin");
   a_hw_buildout: assert property (!host_mode [*6] ##0 age == 3'h7
      |-> build_out_enable[0] == !($past(build_out_select[0], 3) || $past(rate_select_e3[0], 3)))
      else $error("build-out does not follow pins");
   a_hw_rate: assert property (!host_mode [*6] ##0 age == 3'h7
      |-> rate_is_e3[0] == $past(rate_select_e3[0], 3))
      else $error("rate does not follow pin");
endmodule
bind tlce_top tlce_chk #(.CNT_W(CNT_W)) chk (.*);

// ### tlce_framer.sv
// Far-end framer model: transmit line clock and rail data
`timescale 1ns/1ps
module tlce_framer (
   output logic [1:0] tx_line_clock,
   output logic [1:0] tx_positive_rail,
   output logic [1:0] tx_negative_rail
);
   initial begin
      tx_line_clock = 2'h0;
      tx_positive_rail = 2'h0;
      tx_negative_rail = 2'h0;
   end
   // Clock idles low between frames; data moves far from the fall
   task automatic send(input int ch, input logic p, input logic n, input logic sr);
      tx_line_clock[ch] = 1'b1;
      tx_positive_rail[ch] = p;
      tx_negative_rail[ch] = n;
      #62.5;
      tx_line_clock[ch] = 1'b0;
      #40;
      // Hold time over: stale data would hide sampling slips
      tx_positive_rail[ch] = ~p;
      if (!sr)
         tx_negative_rail[ch] = ~n;
      #22.5;
   endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the two-channel transmit encoder
`timescale 1ns/1ps
module tb_top;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        host_mode = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0]  rail_format_select = 2'h0;
   logic [1:0]  build_out_select = 2'h0;
   logic [1:0]  rate_select_e3 = 2'h0;
   logic [1:0]  rate_select_sts1 = 2'h0;
   wire  [1:0]  tx_line_clock, tx_positive_rail, tx_negative_rail;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [1:0]  line_pos, line_neg, line_bit_strobe;
   logic [1:0]  build_out_enable, rate_is_e3, rate_is_sts1, rx_decoder_enable;
   int          bad_count = 0;
   int          tests_run = 0;
   logic [1:0]  ex[$];
   logic [1:0]  cap[2][$];

   always #4 mclk = ~mclk;
   tlce_top dut (.*);
   tlce_framer far (.*);

   always @(posedge mclk) begin
      for (int c = 0; c < 2; c++)
         if (line_bit_strobe[c])
            cap[c].push_back({line_pos[c], line_neg[c]});
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic send_seq(input int ch, input logic [63:0] p, input logic [63:0] n, input int len,
                           input logic sr);
      for (int i = 0; i < len; i++)
         far.send(ch, p[i], n[i], sr);
   endtask

   // Expected marks as {pos, neg}; parity starts even, first mark positive
   task automatic ref_enc(input logic [63:0] s, input int len, input int run);
      logic [1:0] m;
      int odd;
      int z;
      ex.delete();
      m = 2'h1;
      odd = 0;
      z = 0;
      for (int i = 0; i < len; i++) begin
         ex.push_back(2'h0);
         z = s[i] ? 0 : z + 1;
         if (s[i]) begin
            m = ~m;
            ex[i] = m;
            odd = !odd;
         end else if (z == run) begin
            if (!odd) begin
               m = ~m;
               ex[i - run + 1] = m;
            end
            ex[i] = m;
            odd = 0;
            z = 0;
         end
      end
   endtask

   // Latency is whole bit periods of encoder lookahead
   task automatic cmp(input int ch, input int lat, input int len);
      repeat (12) @(posedge mclk);
      check(cap[ch].size(), len);
      for (int i = 0; i + lat < len; i++)
         check(cap[ch][i + lat], ex[i]);
      cap[ch].delete();
   endtask

   task automatic dual_rail();
      logic [7:0] dp;
      logic [7:0] dn;
      dp = 8'hB5;
      dn = 8'h4E;
      ex.delete();
      // One {pos, neg} pair per bit, straight from the two rails
      for (int i = 0; i < 8; i++)
         ex.push_back({dp[i], dn[i]});
      send_seq(0, 64'hB5, 64'h4E, 8, 1'b0);
      cmp(0, 0, 8);
      check(rx_decoder_enable, 2'h0);
   endtask

   task automatic hw_single();
      rate_select_e3 <= 2'h1;
      rail_format_select <= 2'h3;
      repeat (6) @(posedge mclk);
      check(rate_is_e3, 2'h1);
      check(build_out_enable, 2'h2);
      check(rx_decoder_enable, 2'h3);
      fork
         send_seq(0, 64'hF88061, 64'h0, 24, 1'b1);
         send_seq(1, 64'h38981, 64'h0, 18, 1'b1);
      join
      ref_enc(64'hF88061, 24, 4);
      cmp(0, 4, 24);
      ref_enc(64'h38981, 18, 3);
      cmp(1, 3, 18);
      // Long cable on channel 1; E3 pin outranks STS-1 on channel 0
      build_out_select <= 2'h2;
      rate_select_sts1 <= 2'h3;
      repeat (6) @(posedge mclk);
      check(build_out_enable, 2'h0);
      check(rate_is_sts1, 2'h2);
   endtask

   task automatic host_cfg();
      logic [31:0] q;
      logic e;
      host_mode <= 1'b1;
      repeat (6) @(posedge mclk);
      apb(1'b1, 8'h00, 32'h5, q, e);
      apb(1'b1, 8'h04, 32'hA, q, e);
      apb(1'b0, 8'h00, 32'h0, q, e);
      check(q, 32'h5);
      repeat (4) @(posedge mclk);
      check({rate_is_e3, rate_is_sts1, build_out_enable, rx_decoder_enable}, 8'h15);
      send_seq(0, 64'h38981, 64'h3FFFF, 18, 1'b1);
      ref_enc(64'h38981, 18, 3);
      cmp(0, 3, 18);
      apb(1'b0, 8'h08, 32'h0, q, e);
      check(q, 32'h103D);
      apb(1'b1, 8'h08, 32'h20, q, e);
      apb(1'b0, 8'h08, 32'h0, q, e);
      check(q, 32'h101D);
      apb(1'b0, 8'h0C, 32'h0, q, e);
      check(q, 32'h32);
      apb(1'b0, 8'h14, 32'h0, q, e);
      check(q, 32'h6);
      apb(1'b1, 8'h04, 32'h0, q, e);
      repeat (4) @(posedge mclk);
      check({rate_is_e3, build_out_enable}, 4'h9);
      apb(1'b0, 8'h1C, 32'h0, q, e);
      check(e, 1'b1);
      check(q, 32'h0);
   endtask

   initial begin
      #100000;
      bad_count++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      dual_rail();
      hw_single();
      host_cfg();
      test_done();
   end
endmodule
